// File: pin_select_defines.svh
// register offsets, field positions, reset values and widths of the pin-select block
`ifndef PIN_SELECT_DEFINES_SVH
`define PIN_SELECT_DEFINES_SVH

`define PSEL_OFFS_EXT_EXTERNAL_INTERRUPT_TWO    4'h0
`define PSEL_OFFS_OUT_45      4'h4
`define PSEL_OFFS_OUT_67      4'h8
`define PSEL_OFFS_STATUS      4'hC

`define PSEL_CODE_W           5
`define PSEL_LO_FIELD_LSB     0
`define PSEL_HI_FIELD_LSB     8
`define PSEL_INPUT_GROUND     5'h1F

`define PSEL_RESET_INPUT      5'h1F
`define PSEL_RESET_OUTPUT     5'h00
`define PSEL_PORT_LOGIC_CODE  5'h00

`endif

// File: pin_select_pkg.sv
// types shared by the pin-select block
package pin_select_pkg;

  typedef logic [4:0] sel_code_t;

  // bus request as it travels from the slave port into the register file
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [3:0]  adr;
    logic [31:0] dat;
  } bus_req_t;

  // one output-select register: two 5-bit pin fields
  typedef struct packed {
    sel_code_t hiPin;
    sel_code_t loPin;
  } out_pair_t;

endpackage : pin_select_pkg

// File: output_pin_mux.sv
// one remappable output pin: peripheral function selected by a 5-bit code
`timescale 1ns/100ps
`default_nettype none
`include "pin_select_defines.svh"

module output_pin_mux #(
  parameter int NUM_FUNCS = 32
) (
  input  wire logic                           clk,
  input  wire logic                           nrst,
  input  wire pin_select_pkg::sel_code_t      code,
  input  wire logic [NUM_FUNCS-1:0]           periphOut,
  input  wire logic                           portLatch,
  output logic                                pinOut
);

  // refuse function counts that a 5-bit code cannot index
  if (NUM_FUNCS < 2 || NUM_FUNCS > 32) begin : g_bad_funcs
    $error("NUM_FUNCS must lie in 2..32");
  end

  logic next_pinOut;

  // code zero keeps the ordinary port latch, others below NUM_FUNCS pick a peripheral output
  always_comb begin
    if (code == `PSEL_PORT_LOGIC_CODE) begin
      next_pinOut = portLatch;
    end else if (32'(code) < NUM_FUNCS) begin
      next_pinOut = periphOut[code];
    end else begin
      next_pinOut = 1'b0; // code with no function drives low
    end
  end

  // registered pin driver
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pinOut <= 1'b0;
    end else begin
      pinOut <= next_pinOut;
    end
  end

endmodule : output_pin_mux
`default_nettype wire

// File: remappable_pin_select.sv
// peripheral pin-select top: input route for external interrupt two, outputs for pins 4 to 7
//
// Register access over Wishbone and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "pin_select_defines.svh"

module remappable_pin_select #(
  parameter int NUM_PINS   = 26,
  parameter int NUM_FUNCS  = 32,
  parameter bit SMALL_PART = 1'b0
) (
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [3:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic [31:0]                wb_dat_o,
  output logic                       wb_ack_o,
  output logic                       wb_err_o,
  input  wire logic [NUM_PINS-1:0]   remappable_pin,
  input  wire logic [NUM_FUNCS-1:0]  periphOut,
  input  wire logic [3:0]            portLatch,
  output logic [3:0]                 pinOut,
  output logic                       external_interrupt_two
);

  // refuse sizes the route and mux logic cannot index; code 1F must stay free for ground
  if (NUM_PINS < 1 || NUM_PINS > 31) begin : g_bad_pins
    $error("NUM_PINS must lie in 1..31");
  end
  if (NUM_FUNCS < 2 || NUM_FUNCS > 32) begin : g_bad_funcs
    $error("NUM_FUNCS must lie in 2..32");
  end

  pin_select_pkg::bus_req_t  req;
  pin_select_pkg::sel_code_t ext_irq2_input_route;
  pin_select_pkg::out_pair_t remap_pins_4_5_output_select;
  pin_select_pkg::out_pair_t remap_pins_6_7_output_select;
  pin_select_pkg::sel_code_t next_route;
  pin_select_pkg::out_pair_t next_out45;
  pin_select_pkg::out_pair_t next_out67;
  logic [31:0]               next_dat;
  logic                      next_ack;
  logic                      next_err;
  logic                      next_irq;
  logic                      hit;
  logic                      doWrite;

  // field write: byte lane 0 or 1 carries the field, reserved bits dropped
  function automatic pin_select_pkg::sel_code_t write_field(
    input pin_select_pkg::sel_code_t old,
    input logic [7:0]                 lane,
    input logic                       en
  );
    write_field = en ? lane[4:0] : old;
  endfunction : write_field

  // readback places the two fields, all other bits zero
  function automatic logic [31:0] pack_pair(input pin_select_pkg::out_pair_t p);
    pack_pair = {19'h00000, p.hiPin, 3'h0, p.loPin};
  endfunction : pack_pair

  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};

  // address decode; unmapped or misaligned answers with err
  always_comb begin
    unique case (req.adr)
      `PSEL_OFFS_EXT_EXTERNAL_INTERRUPT_TWO, `PSEL_OFFS_OUT_45, `PSEL_OFFS_OUT_67, `PSEL_OFFS_STATUS: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // one-cycle answer, never two back to back
  assign doWrite = req.cyc && req.stb && !wb_ack_o && !wb_err_o && req.we && hit;

  // register file next state
  always_comb begin
    next_route = ext_irq2_input_route;
    next_out45 = remap_pins_4_5_output_select;
    next_out67 = remap_pins_6_7_output_select;
    if (doWrite) begin
      unique case (req.adr)
        `PSEL_OFFS_EXT_EXTERNAL_INTERRUPT_TWO: begin
          next_route = write_field(ext_irq2_input_route, req.dat[7:0], req.sel[0]);
        end
        `PSEL_OFFS_OUT_45: begin
          next_out45.loPin = write_field(remap_pins_4_5_output_select.loPin, req.dat[7:0], req.sel[0]);
          if (!SMALL_PART) begin
            next_out45.hiPin = write_field(remap_pins_4_5_output_select.hiPin, req.dat[15:8], req.sel[1]);
          end
        end
        `PSEL_OFFS_OUT_67: begin
          next_out67.hiPin = write_field(remap_pins_6_7_output_select.hiPin, req.dat[15:8], req.sel[1]);
          if (!SMALL_PART) begin
            next_out67.loPin = write_field(remap_pins_6_7_output_select.loPin, req.dat[7:0], req.sel[0]);
          end
        end
        default: begin
        end
      endcase
    end
  end

  // bus answer and read data
  always_comb begin
    next_ack = 1'b0;
    next_err = 1'b0;
    next_dat = 32'h00000000;
    if (req.cyc && req.stb && !wb_ack_o && !wb_err_o) begin
      next_ack = hit;
      next_err = !hit;
      if (!req.we) begin
        unique case (req.adr)
          `PSEL_OFFS_EXT_EXTERNAL_INTERRUPT_TWO: next_dat = {27'h0000000, ext_irq2_input_route};
          `PSEL_OFFS_OUT_45:   next_dat = pack_pair(remap_pins_4_5_output_select);
          `PSEL_OFFS_OUT_67:   next_dat = pack_pair(remap_pins_6_7_output_select);
          `PSEL_OFFS_STATUS:   next_dat = {27'h0000000, external_interrupt_two, pinOut};
          default:             next_dat = 32'h00000000;
        endcase
      end
    end
  end

  // input route: pin n, grounded, or reserved code reading as ground
  always_comb begin
    if (ext_irq2_input_route == `PSEL_INPUT_GROUND) begin
      next_irq = 1'b0;
    end else if (32'(ext_irq2_input_route) < NUM_PINS) begin
      next_irq = remappable_pin[ext_irq2_input_route];
    end else begin
      next_irq = 1'b0;
    end
  end

  // registers of the bus slave, config and interrupt route
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ext_irq2_input_route         <= `PSEL_RESET_INPUT;
      remap_pins_4_5_output_select <= {`PSEL_RESET_OUTPUT, `PSEL_RESET_OUTPUT};
      remap_pins_6_7_output_select <= {`PSEL_RESET_OUTPUT, `PSEL_RESET_OUTPUT};
      wb_ack_o                     <= 1'b0;
      wb_err_o                     <= 1'b0;
      wb_dat_o                     <= 32'h00000000;
      external_interrupt_two       <= 1'b0;
    end else begin
      ext_irq2_input_route         <= next_route;
      remap_pins_4_5_output_select <= next_out45;
      remap_pins_6_7_output_select <= next_out67;
      wb_ack_o                     <= next_ack;
      wb_err_o                     <= next_err;
      wb_dat_o                     <= next_dat;
      external_interrupt_two       <= next_irq;
    end
  end

  // pin 4 follows the low field of the pins 4-5 register
  output_pin_mux #(
    .NUM_FUNCS(NUM_FUNCS)
  ) u_pin4 (
    .clk       (clk),
    .nrst      (nrst),
    .code      (remap_pins_4_5_output_select.loPin),
    .periphOut (periphOut),
    .portLatch (portLatch[0]),
    .pinOut    (pinOut[0])
  );

  // pin 5: field held at zero on the small part, so the pin stays on its port latch
  output_pin_mux #(
    .NUM_FUNCS(NUM_FUNCS)
  ) u_pin5 (
    .clk       (clk),
    .nrst      (nrst),
    .code      (remap_pins_4_5_output_select.hiPin),
    .periphOut (periphOut),
    .portLatch (portLatch[1]),
    .pinOut    (pinOut[1])
  );

  // pin 6: field held at zero on the small part, so the pin stays on its port latch
  output_pin_mux #(
    .NUM_FUNCS(NUM_FUNCS)
  ) u_pin6 (
    .clk       (clk),
    .nrst      (nrst),
    .code      (remap_pins_6_7_output_select.loPin),
    .periphOut (periphOut),
    .portLatch (portLatch[2]),
    .pinOut    (pinOut[2])
  );

  // pin 7 follows the high field of the pins 6-7 register
  output_pin_mux #(
    .NUM_FUNCS(NUM_FUNCS)
  ) u_pin7 (
    .clk       (clk),
    .nrst      (nrst),
    .code      (remap_pins_6_7_output_select.hiPin),
    .periphOut (periphOut),
    .portLatch (portLatch[3]),
    .pinOut    (pinOut[3])
  );

  // assertions
  a_ground_route: assert property (@(posedge clk) disable iff (!nrst)
    ext_irq2_input_route == `PSEL_INPUT_GROUND |=> !external_interrupt_two)
    else $error("grounded route drove the interrupt input");

  a_pin_route: assert property (@(posedge clk) disable iff (!nrst)
    32'(ext_irq2_input_route) < NUM_PINS |=> external_interrupt_two == $past(remappable_pin[ext_irq2_input_route]))
    else $error("interrupt input does not follow the selected pin");

  a_pin5_field: assert property (@(posedge clk) disable iff (!nrst || SMALL_PART)
    doWrite && req.adr == `PSEL_OFFS_OUT_45 && req.sel[1] |=> remap_pins_4_5_output_select.hiPin == $past(req.dat[12:8]))
    else $error("pin 5 field not written from bits 12-8");

  a_pin4_field: assert property (@(posedge clk) disable iff (!nrst)
    doWrite && req.adr == `PSEL_OFFS_OUT_45 && req.sel[0] |=> remap_pins_4_5_output_select.loPin == $past(req.dat[4:0]))
    else $error("pin 4 field not written from bits 4-0");

  a_pin7_field: assert property (@(posedge clk) disable iff (!nrst)
    doWrite && req.adr == `PSEL_OFFS_OUT_67 && req.sel[1] |=> remap_pins_6_7_output_select.hiPin == $past(req.dat[12:8]))
    else $error("pin 7 field not written from bits 12-8");

  a_small_absent: assert property (@(posedge clk) disable iff (!nrst)
    SMALL_PART |-> remap_pins_4_5_output_select.hiPin == 5'h00 && remap_pins_6_7_output_select.loPin == 5'h00)
    else $error("absent field holds a value on the small part");

  a_reserved_zero: assert property (@(posedge clk) disable iff (!nrst)
    wb_ack_o && $past(req.adr) != `PSEL_OFFS_STATUS |-> wb_dat_o[31:13] == 19'h00000 && wb_dat_o[7:5] == 3'h0)
    else $error("unimplemented bits read nonzero");

  a_pin6_field: assert property (@(posedge clk) disable iff (!nrst || SMALL_PART)
    doWrite && req.adr == `PSEL_OFFS_OUT_67 && req.sel[0] |=> remap_pins_6_7_output_select.loPin == $past(req.dat[4:0]))
    else $error("pin 6 field not written from bits 4-0");

  sequence s_pin4_write;
    doWrite && req.adr == `PSEL_OFFS_OUT_45 && req.sel[0] && req.dat[4:0] == 5'h00;
  endsequence

  a_port_logic: assert property (@(posedge clk) disable iff (!nrst)
    s_pin4_write ##1 (remap_pins_4_5_output_select.loPin == 5'h00) |=> pinOut[0] == $past(portLatch[0]))
    else $error("code zero does not pass the port latch to pin 4");

  a_route_reserved: assert property (@(posedge clk) disable iff (!nrst)
    ext_irq2_input_route != `PSEL_INPUT_GROUND && 32'(ext_irq2_input_route) >= NUM_PINS
    |=> !external_interrupt_two)
    else $error("reserved route code drove the interrupt input");

  a_pin4_drive: assert property (@(posedge clk) disable iff (!nrst)
    remap_pins_4_5_output_select.loPin != 5'h00 && 32'(remap_pins_4_5_output_select.loPin) < NUM_FUNCS
    |=> pinOut[0] == $past(periphOut[remap_pins_4_5_output_select.loPin]))
    else $error("pin 4 does not follow its selected function");

  a_pin7_drive: assert property (@(posedge clk) disable iff (!nrst)
    remap_pins_6_7_output_select.hiPin != 5'h00 && 32'(remap_pins_6_7_output_select.hiPin) < NUM_FUNCS
    |=> pinOut[3] == $past(periphOut[remap_pins_6_7_output_select.hiPin]))
    else $error("pin 7 does not follow its selected function");

  a_small_pins: assert property (@(posedge clk) disable iff (!nrst)
    SMALL_PART |=> pinOut[1] == $past(portLatch[1]) && pinOut[2] == $past(portLatch[2]))
    else $error("unrouted pin left its port latch on the small part");

  // no register moves in the cycle after a refused or ignored request
  sequence s_regs_held;
    $stable(ext_irq2_input_route) && $stable(remap_pins_4_5_output_select)
      && $stable(remap_pins_6_7_output_select);
  endsequence

  a_status_ro: assert property (@(posedge clk) disable iff (!nrst)
    doWrite && req.adr == `PSEL_OFFS_STATUS |=> s_regs_held)
    else $error("write to the status word changed a register");

  a_err_no_write: assert property (@(posedge clk) disable iff (!nrst)
    req.cyc && req.stb && !hit |=> s_regs_held)
    else $error("unmapped access changed a register");

  a_answer_next: assert property (@(posedge clk) disable iff (!nrst)
    req.cyc && req.stb && !wb_ack_o && !wb_err_o |=> wb_ack_o != wb_err_o)
    else $error("request not answered by exactly one of ack or err");

  a_ack_pulse: assert property (@(posedge clk) disable iff (!nrst)
    wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o)
    else $error("answer stood longer than one cycle");

  a_dat_idle: assert property (@(posedge clk) disable iff (!nrst)
    !wb_ack_o |-> wb_dat_o == 32'h00000000)
    else $error("read data not zero outside an ack");

endmodule : remappable_pin_select
`default_nettype wire

// File: pin_partner_model.sv
// far side model: remappable pin levels, peripheral outputs and port latches
`timescale 1ns/100ps
`default_nettype none

module pin_partner_model (
  input  wire logic   phase,
  output logic [25:0] remappable_pin,
  output logic [31:0] periphOut,
  output logic [3:0]  portLatch
);
  // two opposite patterns so every routed bit is seen at both levels
  always_comb begin
    remappable_pin = phase ? 26'h2AA_AAAA : 26'h155_5555;
    periphOut      = phase ? 32'h6C3A_91E5 : 32'h93C5_6E1A;
    portLatch      = phase ? 4'hA : 4'h5;
  end
endmodule : pin_partner_model

`default_nettype wire

// File: remappable_pin_select_tb_top.sv
// self-checking bench for the pin-select block: registers, routing and pin timing
`timescale 1ns/100ps
`default_nettype none

module remappable_pin_select_tb_top;
  logic                      clk = 1'b0;
  logic                      nrst = 1'b0;
  logic                      phase = 1'b0;
  pin_select_pkg::bus_req_t  req = '0;
  logic [31:0]               datMain, datSmall, rd, rdS;
  logic                      ack, err, ackSmall, errSmall, intTwo, intSmall, gotErr;
  logic [3:0]                pinOut, pinSmall, latch, pinAtAck;
  logic [25:0]               pins;
  logic [31:0]               funcs;
  int                        bad_count = 0;
  int                        comparisons = 0;
  int                        cycles = 0;

  pin_partner_model u_pin_partner_model (.phase(phase), .remappable_pin(pins), .periphOut(funcs), .portLatch(latch));

  remappable_pin_select u_remappable_pin_select (.clk(clk), .nrst(nrst), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
    .wb_we_i(req.we), .wb_adr_i(req.adr), .wb_sel_i(req.sel), .wb_dat_i(req.dat), .wb_dat_o(datMain), .wb_ack_o(ack),
    .wb_err_o(err), .remappable_pin(pins), .periphOut(funcs), .portLatch(latch), .pinOut(pinOut),
    .external_interrupt_two(intTwo));

  remappable_pin_select #(.SMALL_PART(1'b1)) u_remappable_pin_select_small (.clk(clk), .nrst(nrst),
    .wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_we_i(req.we), .wb_adr_i(req.adr), .wb_sel_i(req.sel),
    .wb_dat_i(req.dat), .wb_dat_o(datSmall), .wb_ack_o(ackSmall), .wb_err_o(errSmall), .remappable_pin(pins),
    .periphOut(funcs), .portLatch(latch), .pinOut(pinSmall), .external_interrupt_two(intSmall));

  // free-running clock, 100 MHz
  always #5 clk = ~clk;

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one classic cycle: raise after an edge, hold until ack or err is sampled, take data at that edge, release
  task automatic bus(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{1'b1, 1'b1, w, s, a, d};
    @(posedge clk);
    while (!(ack || err)) begin
      @(posedge clk);
      n++;
    end
    check("answer", ack | err, 1'b1);
    check("answer delay", n, 1);
    check("small answer", ackSmall | errSmall, 1'b1);
    rd = datMain;
    rdS = datSmall;
    gotErr = err;
    pinAtAck = pinOut;
    req <= '0;
    @(negedge clk);
  endtask : bus

  // cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      test_done();
    end
  end

  initial begin
    logic [4:0] codes [5] = '{5'h00, 5'h01, 5'h19, 5'h1E, 5'h1F};
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    // reset values; code zero keeps the port latch on the pins
    bus(1'b0, 4'h0, 4'hF, 32'h0);
    check("route reset", rd, 32'h1F);
    bus(1'b0, 4'h4, 4'hF, 32'h0);
    check("pins45 reset", rd, 32'h0);
    check("port latch", pinOut, latch);
    // field positions, reserved bits, small variant
    bus(1'b1, 4'h4, 4'hF, 32'hFFFF_E3E5);
    bus(1'b0, 4'h4, 4'hF, 32'h0);
    check("pins45 fields", rd, 32'h0305);
    check("small pins45", rdS, 32'h0005);
    check("pin4 func", pinOut[0], funcs[5]);
    check("pin5 func", pinOut[1], funcs[3]);
    check("small pin5", pinSmall[1], latch[1]);
    // new code reaches the pin one edge after the write edge
    bus(1'b1, 4'h8, 4'hF, 32'h0000_0706);
    check("pins67 at ack", pinAtAck[3:2], latch[3:2]);
    check("pins67 after", pinOut[3:2], {funcs[7], funcs[6]});
    check("small pin6", pinSmall[2], latch[2]);
    bus(1'b0, 4'h8, 4'hF, 32'h0);
    check("pins67 fields", rd, 32'h0706);
    check("small pins67", rdS, 32'h0700);
    // upper lane only: pin4 field untouched
    bus(1'b1, 4'h4, 4'h2, 32'h0000_1F1F);
    bus(1'b0, 4'h4, 4'hF, 32'h0);
    check("lane write", rd, 32'h1F05);
    // input route: pins, top pin, reserved code and ground
    foreach (codes[i]) begin
      bus(1'b1, 4'h0, 4'hF, {27'h7FF_FFFF, codes[i]});
      bus(1'b0, 4'h0, 4'hF, 32'h0);
      check("route field", rd, {27'h0, codes[i]});
      for (int p = 0; p < 2; p++) begin
        @(posedge clk);
        phase <= p[0];
        @(posedge clk);
        @(negedge clk);
        check("route level", intTwo, (codes[i] < 5'h1A) ? pins[codes[i]] : 1'b0);
        check("small route", intSmall, (codes[i] < 5'h1A) ? pins[codes[i]] : 1'b0);
      end
    end
    // unmapped address, ignored write to status, status contents
    bus(1'b0, 4'h2, 4'hF, 32'h0);
    check("unmapped err", gotErr, 1'b1);
    bus(1'b1, 4'h6, 4'hF, 32'hFFFF_FFFF);
    check("unmapped write err", gotErr, 1'b1);
    bus(1'b1, 4'hC, 4'hF, 32'hFFFF_FFFF);
    bus(1'b0, 4'hC, 4'hF, 32'h0);
    check("status", rd, {28'h0, funcs[7], funcs[6], funcs[31], funcs[5]});
    // code zero hands pin 4 back to its port latch
    bus(1'b1, 4'h4, 4'h1, 32'h0);
    check("pin4 port", pinOut[0], latch[0]);
    bus(1'b0, 4'h4, 4'hF, 32'h0);
    check("pin4 cleared", rd, 32'h1F00);
    test_done();
  end
endmodule : remappable_pin_select_tb_top

`default_nettype wire
